// ### dpgpio_change.sv
// Purpose: change detector on the monitored upper pins of the 8-bit port
// Assumes: pin levels already synchronised
// Notes: snapshot refreshed on every read or write of the port
`timescale 1ns/100ps
module dpgpio_change
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] pin_level,
   input wire logic [3:0] dir_input,
   input wire logic port_access,
   input wire logic flag_clear,
   output logic port_change_flag_ff,
   output logic mismatch
);
   logic [3:0] snap_ff;
   wire [3:0] bit_mismatch;
   wire nxt_flag;

   assign bit_mismatch = (pin_level ^ snap_ff) & dir_input;
   assign mismatch = |bit_mismatch;
   // Set wins over clear while mismatch persists
   assign nxt_flag = mismatch | (port_change_flag_ff & ~flag_clear);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         snap_ff <= 4'h0;
         port_change_flag_ff <= 1'b0;
      end
      else
      begin
         if (port_access)
         begin
            snap_ff <= pin_level;
         end
         port_change_flag_ff <= nxt_flag;
      end
   end
endmodule

// ### dpgpio_pins.sv
// Purpose: board model resolving the pin levels
// Assumes: driver wins, then board drive, then pull-up
// Notes: floating pins toggle every cycle
`timescale 1ns/100ps
module dpgpio_pins
(
   input wire logic pclk,
   input wire logic [4:0] a_out,
   input wire logic [4:0] a_oe,
   input wire logic [7:0] b_out,
   input wire logic [7:0] b_oe,
   input wire logic [7:0] pu,
   input wire logic [4:0] xa_en,
   input wire logic [4:0] xa_val,
   input wire logic [7:0] xb_en,
   input wire logic [7:0] xb_val,
   output logic [4:0] a_in,
   output logic [7:0] b_in
);
   logic float_ff = 1'b0;
   always_ff @(posedge pclk)
   begin
      float_ff <= ~float_ff;
   end
   assign a_in = (a_oe & a_out) | (~a_oe & ((xa_en & xa_val) | (~xa_en & {5{float_ff}})));
   assign b_in = (b_oe & b_out) | (~b_oe & ((xb_en & xb_val) | (~xb_en & (pu | {8{float_ff}}))));
endmodule

// ### dpgpio_pkg.sv
// Purpose: constants for the dual-port GPIO block
// Assumes: APB with 32-bit data, register offsets as word indexes
// Notes: byte address is four times the register index
package dpgpio_pkg;
   localparam int unsigned DPGPIO_A_WIDTH = 5;
   localparam int unsigned DPGPIO_B_WIDTH = 8;
   localparam logic [7:0] DPGPIO_IDX_A_DATA = 8'h05;
   localparam logic [7:0] DPGPIO_IDX_B_DATA = 8'h06;
   localparam logic [7:0] DPGPIO_IDX_CONFIG = 8'h81;
   localparam logic [7:0] DPGPIO_IDX_A_DIR = 8'h85;
   localparam logic [7:0] DPGPIO_IDX_B_DIR = 8'h86;
   localparam logic [7:0] DPGPIO_IDX_STATUS = 8'h87;
   localparam logic [7:0] DPGPIO_IDX_SLEEP = 8'h88;
   localparam logic [7:0] DPGPIO_RST_CONFIG = 8'hFF;
   localparam logic [4:0] DPGPIO_RST_A_DIR = 5'h1F;
   localparam logic [7:0] DPGPIO_RST_B_DIR = 8'hFF;
   localparam int unsigned DPGPIO_PULLUP_BIT = 7;
   localparam int unsigned DPGPIO_ODRAIN_BIT = 4;
   localparam int unsigned DPGPIO_FLAG_BIT = 0;
   localparam int unsigned DPGPIO_WAKE_BIT = 1;
endpackage

// ### dpgpio_sync.sv
// Purpose: two-flop synchroniser for a bus of pin levels
// Assumes: pins are asynchronous to pclk
// Notes: first stage read only by the second
`timescale 1ns/100ps
module dpgpio_sync
#(
   parameter int unsigned WIDTH = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_ff <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_out <= meta_ff;
      end
   end
endmodule

// ### dpgpio_top.sv
// Purpose: two GPIO ports with pull-ups and change detection behind APB
// Assumes: pclk 100 MHz, pins asynchronous, sleep request from core
// Notes: one APB cycle stands for one instruction cycle
// Operation
// - First port is a five-bit output latch with a direction bit per pin.
// - First port direction one tristates the driver, zero drives the latch.
// - Data reads return pin levels; data writes load the output latch.
// - First port bit 4 is open drain, pulls only low, Schmitt input.
// - First port bit 4 also feeds the timer external clock input.
// - Unimplemented first port data and direction bits read as zero.
// - Second port is eight-bit bidirectional; direction one tristates, zero drives.
// - Clearing option bit 7 enables all second port weak pull-ups.
// - A second port pull-up is off whenever that pin is an output.
// - Pull-ups are disabled after power-on reset.
// - Change detection covers only upper four second port pins set as inputs.
// - Monitored pins compare with value captured at last port read or write; mismatches ORed.
// - Mismatch keeps setting the flag; software ends mismatch then clears.
// - The port change event can wake the device from sleep.
// - Second port bit 0 also serves as the external interrupt input.
// - Second port bits 6 and 7 carry serial programming clock and data.
// - Port writes are read-modify-write; input latch bits may take pin levels.
// - Writes act at cycle end; read data is sampled at cycle start; here both are taken at the edge that ends the setup phase.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module dpgpio_top
import dpgpio_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [4:0] five_bit_port_in,
   output logic [4:0] five_bit_port_out,
   output logic [4:0] five_bit_port_oe,
   input wire logic [7:0] eight_bit_port_in,
   output logic [7:0] eight_bit_port_out,
   output logic [7:0] eight_bit_port_oe,
   output logic [7:0] eight_bit_pullup_en,
   input wire logic sleep_req,
   output logic timer_clock_in,
   output logic external_interrupt_pin,
   output logic serial_program_clock_pin,
   output logic serial_program_data_pin,
   output logic port_change_flag,
   output logic wake_up
);
   ////////////////////////////////////////////////////////////////////////
   // Registers and pin synchronisers
   logic [4:0] a_latch_ff;
   logic [4:0] a_dir_ff;
   logic [7:0] b_latch_ff;
   logic [7:0] b_dir_ff;
   logic [7:0] config_ff;
   logic sleep_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [4:0] a_pin_sync;
   logic [7:0] b_pin_sync;
   logic [4:0] a_pin_ff;
   logic [7:0] b_pin_ff;
   logic change_flag_int;
   logic change_mismatch;
   logic wake_ff;
   logic alt_ff;
   logic ext_int_ff;
   logic prog_clock_ff;
   logic prog_data_ff;
   logic change_out_ff;

   dpgpio_sync #(.WIDTH(DPGPIO_A_WIDTH)) u_sync_a
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(five_bit_port_in),
      .sync_out(a_pin_sync)
   );

   dpgpio_sync #(.WIDTH(DPGPIO_B_WIDTH)) u_sync_b
   (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(eight_bit_port_in),
      .sync_out(b_pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
      hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
   endfunction

   wire setup_phase;
   wire wr_en;
   wire rd_en;
   wire sel_a_data;
   wire sel_b_data;
   wire sel_config;
   wire sel_a_dir;
   wire sel_b_dir;
   wire sel_status;
   wire sel_sleep;
   wire sel_any;
   wire flag_clear;
   wire wake_clear;
   wire b_access;
   wire [31:0] rd_mux;

   wire wr_a_data;
   wire wr_b_data;
   wire wr_a_dir;
   wire wr_b_dir;
   wire wr_config;
   wire wr_sleep;

   // Zero-wait answer: pready rises in the first access cycle
   assign setup_phase = psel & ~penable;
   assign wr_en = setup_phase & pwrite;
   assign rd_en = setup_phase & ~pwrite;
   assign sel_a_data = hit(paddr, DPGPIO_IDX_A_DATA);
   assign sel_b_data = hit(paddr, DPGPIO_IDX_B_DATA);
   assign sel_config = hit(paddr, DPGPIO_IDX_CONFIG);
   assign sel_a_dir = hit(paddr, DPGPIO_IDX_A_DIR);
   assign sel_b_dir = hit(paddr, DPGPIO_IDX_B_DIR);
   assign sel_status = hit(paddr, DPGPIO_IDX_STATUS);
   assign sel_sleep = hit(paddr, DPGPIO_IDX_SLEEP);
   assign sel_any = sel_a_data | sel_b_data | sel_config | sel_a_dir | sel_b_dir | sel_status | sel_sleep;
   assign flag_clear = wr_en & sel_status & pwdata[DPGPIO_FLAG_BIT];
   assign b_access = setup_phase & sel_b_data;
   // Wake clears only together with the flag bit
   assign wake_clear = flag_clear & pwdata[DPGPIO_WAKE_BIT];
   // Per-register write strobes, taken at the setup edge
   assign wr_a_data = wr_en & sel_a_data;
   assign wr_b_data = wr_en & sel_b_data;
   assign wr_a_dir = wr_en & sel_a_dir;
   assign wr_b_dir = wr_en & sel_b_dir;
   assign wr_config = wr_en & sel_config;
   assign wr_sleep = wr_en & sel_sleep;

   // Data reads return pins, other reads return registers, unimplemented bits zero
   assign rd_mux = sel_a_data ? {27'h0, a_pin_sync} :
                   sel_b_data ? {24'h0, b_pin_sync} :
                   sel_config ? {24'h0, config_ff} :
                   sel_a_dir ? {27'h0, a_dir_ff} :
                   sel_b_dir ? {24'h0, b_dir_ff} :
                   sel_status ? {30'h0, wake_ff, change_flag_int} :
                   sel_sleep ? {31'h0, sleep_ff} :
                   32'h0;

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_latch_ff <= 5'h00;
         b_latch_ff <= 8'h00;
         a_dir_ff <= DPGPIO_RST_A_DIR;
         b_dir_ff <= DPGPIO_RST_B_DIR;
         config_ff <= DPGPIO_RST_CONFIG;
         sleep_ff <= 1'b0;
      end
      else
      begin
         // Whole byte written; software supplies read-modified value
         if (wr_a_data)
         begin
            a_latch_ff <= pwdata[4:0];
         end
         if (wr_b_data)
         begin
            b_latch_ff <= pwdata[7:0];
         end
         if (wr_a_dir)
         begin
            a_dir_ff <= pwdata[4:0];
         end
         if (wr_b_dir)
         begin
            b_dir_ff <= pwdata[7:0];
         end
         if (wr_config)
         begin
            config_ff <= pwdata[7:0];
         end
         if (wr_sleep)
         begin
            sleep_ff <= pwdata[0];
         end
         else if (wake_ff)
         begin
            sleep_ff <= 1'b0;
         end
         // Core may also request sleep directly
         else if (sleep_req)
         begin
            sleep_ff <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0;
      end
      else
      begin
         pready_ff <= setup_phase;
         pslverr_ff <= setup_phase & ~sel_any;
         prdata_ff <= rd_en ? rd_mux : 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Change detection and wake
   dpgpio_change u_change
   (
      .pclk(pclk),
      .presetn(presetn),
      .pin_level(b_pin_sync[7:4]),
      .dir_input(b_dir_ff[7:4]),
      .port_access(b_access),
      .flag_clear(flag_clear),
      .port_change_flag_ff(change_flag_int),
      .mismatch(change_mismatch)
   );

   wire nxt_wake;
   assign nxt_wake = (sleep_ff & change_mismatch) | (wake_ff & ~wake_clear);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_ff <= 1'b0;
      end
      else
      begin
         wake_ff <= nxt_wake;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers, pull-ups and alternate functions
   wire [4:0] a_oe;
   wire [4:0] a_out;
   wire [7:0] b_oe;
   wire [7:0] pull;

   generate
      for (genvar gi = 0; gi < DPGPIO_A_WIDTH; gi = gi + 1)
      begin : g_a_pin
         if (gi == DPGPIO_ODRAIN_BIT)
         begin : g_odrain
            // Open drain: drive only when latch is low
            assign a_oe[gi] = ~a_dir_ff[gi] & ~a_latch_ff[gi];
            assign a_out[gi] = 1'b0;
         end
         else
         begin : g_push_pull
            assign a_oe[gi] = ~a_dir_ff[gi];
            assign a_out[gi] = a_latch_ff[gi];
         end
      end
      // Second port drivers follow the direction bits
      for (genvar gj = 0; gj < DPGPIO_B_WIDTH; gj = gj + 1)
      begin : g_b_pin
         assign b_oe[gj] = ~b_dir_ff[gj];
         // Pull-up only while the pin is an input
         assign pull[gj] = ~config_ff[DPGPIO_PULLUP_BIT] & b_dir_ff[gj];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         five_bit_port_out <= 5'h00;
         five_bit_port_oe <= 5'h00;
         eight_bit_port_out <= 8'h00;
         eight_bit_port_oe <= 8'h00;
         eight_bit_pullup_en <= 8'h00;
         a_pin_ff <= 5'h00;
         b_pin_ff <= 8'h00;
      end
      else
      begin
         five_bit_port_out <= a_out;
         five_bit_port_oe <= a_oe;
         eight_bit_port_out <= b_latch_ff;
         eight_bit_port_oe <= b_oe;
         eight_bit_pullup_en <= pull;
         a_pin_ff <= a_pin_sync;
         b_pin_ff <= b_pin_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alt_ff <= 1'b0;
         ext_int_ff <= 1'b0;
         prog_clock_ff <= 1'b0;
         prog_data_ff <= 1'b0;
         change_out_ff <= 1'b0;
      end
      else
      begin
         // Alternate functions see pin levels, not the latch
         alt_ff <= a_pin_ff[DPGPIO_ODRAIN_BIT];
         ext_int_ff <= b_pin_ff[0];
         prog_clock_ff <= b_pin_ff[6];
         prog_data_ff <= b_pin_ff[7];
         change_out_ff <= change_flag_int;
      end
   end

   assign timer_clock_in = alt_ff;
   assign serial_program_data_pin = prog_data_ff;
   assign serial_program_clock_pin = prog_clock_ff;
   assign external_interrupt_pin = ext_int_ff;
   assign port_change_flag = change_out_ff;
   assign wake_up = wake_ff;
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
endmodule

// ### dpgpio_top_asserts.sv
// Purpose: port-level checks of the GPIO block
// Assumes: one pclk domain, async presetn
// Notes: bound from the bench top
`timescale 1ns/100ps
module dpgpio_top_asserts
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [4:0] five_bit_port_in,
   input wire logic [4:0] five_bit_port_out,
   input wire logic [7:0] eight_bit_port_in,
   input wire logic [7:0] eight_bit_port_oe,
   input wire logic [7:0] eight_bit_pullup_en,
   input wire logic timer_clock_in,
   input wire logic external_interrupt_pin,
   input wire logic serial_program_clock_pin,
   input wire logic serial_program_data_pin,
   input wire logic wake_up
);
   logic [2:0] run_ff;
   logic [2:0] nxt_run;
   logic wake_clr;
   assign nxt_run = (run_ff == 3'h7) ? run_ff : run_ff + 3'h1;
   assign wake_clr = psel && !penable && pwrite && paddr == 12'h21C;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         run_ff <= 3'h0;
      else
         run_ff <= nxt_run;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_odrain_low: assert property (!five_bit_port_out[4])
      else $error("open drain drives high");
   a_pullup_output: assert property ((eight_bit_pullup_en & eight_bit_port_oe) == 8'h00)
      else $error("pull-up on output pin");
   a_pullup_reset: assert property ($rose(presetn) |-> eight_bit_pullup_en == 8'h00)
      else $error("pull-up on after reset");
   a_timer_follow: assert property (run_ff == 3'h7 |-> timer_clock_in == $past(five_bit_port_in[4], 4))
      else $error("timer clock not pin level");
   a_int_follow: assert property (run_ff == 3'h7 |-> external_interrupt_pin == $past(eight_bit_port_in[0], 4))
      else $error("interrupt pin not pin level");
   a_serial_follow: assert property (run_ff == 3'h7 |->
      {serial_program_data_pin, serial_program_clock_pin} == $past(eight_bit_port_in[7:6], 4))
      else $error("serial pins not pin level");
   a_wake_hold: assert property (wake_up && !wake_clr |=> wake_up)
      else $error("wake dropped");
endmodule

// ### dual_port_gpio_with_change_irq_tb_top.sv
// Purpose: self-checking bench of the GPIO block
// Assumes: one-cycle APB answer, pins settle in 4 cycles
// Notes: bus task waits on pready with a bound
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module dual_port_gpio_with_change_irq_tb_top
import dpgpio_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, sleep_req, pready, pslverr, err;
   logic tck, eint, spc, spd, pcf, wake;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] a_in, a_out, a_oe, xa_en, xa_val;
   logic [7:0] b_in, b_out, b_oe, pu, xb_en, xb_val;
   int fail_count, comparisons;
   dpgpio_top i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .five_bit_port_in(a_in), .five_bit_port_out(a_out), .five_bit_port_oe(a_oe), .eight_bit_port_in(b_in),
      .eight_bit_port_out(b_out), .eight_bit_port_oe(b_oe), .eight_bit_pullup_en(pu), .sleep_req(sleep_req),
      .timer_clock_in(tck), .external_interrupt_pin(eint), .serial_program_clock_pin(spc),
      .serial_program_data_pin(spd), .port_change_flag(pcf), .wake_up(wake));
   dpgpio_pins i_pins(.pclk(pclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .pu(pu),
      .xa_en(xa_en), .xa_val(xa_val), .xb_en(xb_en), .xb_val(xb_val), .a_in(a_in), .b_in(b_in));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         fail_count++;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      `CHK(a_oe, 5'h00)
      `CHK(pu, 8'h00)
      bus(1'b0, 12'h204, 32'h0);
      `CHK(rd, 32'h000000FF)
      bus(1'b0, 12'h214, 32'h0);
      `CHK(rd, 32'h0000001F)
      bus(1'b0, 12'h218, 32'h0);
      `CHK(rd, 32'h000000FF)
      $display("test reset done");
   endtask
   task automatic t_port_a();
      xa_en <= 5'h10;
      xa_val <= 5'h10;
      bus(1'b1, 12'h214, 32'hFF);
      bus(1'b0, 12'h214, 32'h0);
      `CHK(rd, 32'h0000001F)
      bus(1'b1, 12'h214, 32'h0);
      bus(1'b1, 12'h14, 32'h1A);
      idle(3);
      `CHK(a_out[3:0], 4'hA)
      `CHK(a_oe, 5'h0F)
      bus(0, 12'h14, 32'h0);
      `CHK(rd, 32'h0000001A)
      bus(1'b1, 12'h14, 32'h05);
      idle(3);
      `CHK(a_oe, 5'h1F)
      bus(1'b0, 12'h14, 32'h0);
      `CHK(rd, 32'h00000005)
      bus(1'b1, 12'h214, 32'h1F);
      idle(6);
      `CHK(a_oe, 5'h00)
      `CHK(tck, 1'b1)
      $display("test first port done");
   endtask
   task automatic t_port_b();
      bus(1'b1, 12'h218, 32'h0F);
      bus(1'b1, 12'h204, 32'h7F);
      bus(1'b1, 12'h18, 32'hA5);
      idle(6);
      `CHK(b_oe, 8'hF0)
      `CHK(pu, 8'h0F)
      `CHK(b_out[7:4], 4'hA)
      `CHK(eint, 1'b1)
      `CHK({spd, spc}, 2'b10)
      bus(1'b0, 12'h18, 32'h0);
      `CHK(rd, 32'h000000AF)
      bus(1'b1, 12'h204, 32'hFF);
      idle(2);
      `CHK(pu, 8'h00)
      $display("test second port done");
   endtask
   task automatic t_change();
      int n;
      xb_en <= 8'hFF;
      xb_val <= 8'hF0;
      bus(1'b1, 12'h218, 32'hFF);
      idle(4);
      bus(1'b0, 12'h18, 32'h0);
      bus(1'b1, 12'h21C, 32'h1);
      xb_val <= 8'hF7;
      idle(6);
      `CHK(pcf, 1'b0)
      bus(1'b1, 12'h220, 32'h1);
      xb_val <= 8'h77;
      n = 0;
      while (pcf !== 1'b1 && n < 10)
      begin
         @(posedge pclk);
         n++;
      end
      `CHK(pcf, 1'b1)
      `CHK(wake, 1'b1)
      bus(1'b1, 12'h21C, 32'h1);
      idle(3);
      `CHK(pcf, 1'b1)
      bus(1'b0, 12'h18, 32'h0);
      `CHK(rd, 32'h00000077)
      bus(1'b1, 12'h21C, 32'h3);
      idle(3);
      `CHK(pcf, 1'b0)
      `CHK(wake, 1'b0)
      bus(1'b1, 12'h218, 32'h7F);
      idle(6);
      `CHK(pcf, 1'b0)
      sleep_req <= 1'b1;
      idle(1);
      sleep_req <= 1'b0;
      bus(1'b0, 12'h220, 32'h0);
      `CHK(rd, 32'h00000001)
      $display("test change done");
   endtask
   task automatic t_unmapped();
      bus(1'b0, 12'h000, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      bus(1'b1, 12'h015, 32'hFF);
      `CHK(err, 1'b1)
      $display("test unmapped done");
   endtask
   ////////////////////////////////////////
   initial
   begin
      {presetn, psel, penable, pwrite, sleep_req} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      {xa_en, xa_val} = 10'h000;
      {xb_en, xb_val} = 16'h0000;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_port_a();
      t_port_b();
      t_change();
      t_unmapped();
      end_sim();
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      end_sim();
   end
endmodule
bind dpgpio_top dpgpio_top_asserts i_chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .five_bit_port_in(five_bit_port_in), .five_bit_port_out(five_bit_port_out),
   .eight_bit_port_in(eight_bit_port_in), .eight_bit_port_oe(eight_bit_port_oe),
   .eight_bit_pullup_en(eight_bit_pullup_en), .timer_clock_in(timer_clock_in),
   .external_interrupt_pin(external_interrupt_pin), .serial_program_clock_pin(serial_program_clock_pin),
   .serial_program_data_pin(serial_program_data_pin), .wake_up(wake_up));
